//--- src/ppm_top.sv
// Top of the palette pixel port multiplexer: pin synchronisers, mode
// decode, bus-load capture, group shifting and palette or DAC output.
// Assumes pixel source pins asynchronous to clk_i and strobes far slower
// than clk_i, so that every edge of each strobe is seen after two flops.
`timescale 1ns/1ps

// Summary of operation
// - Capture whole bus load on shift edge, emit groups per dot, lowest first unless big-endian.
// - Divide ratio equals pixels per load; one shift edge delivers them all.
// - Only mux code bits 5..0 select the mode; bits 6, 7 ignored.
// - After reset the block runs VGA pass-through, mode 0.
// - Selecting pass-through resets clock select, general control, read mask.
// - Pass-through input timing follows the first clock source input.
// - Normal modes sample pixel data and controls on the shift clock.
// - Normal modes take 8, 16, 32-bit buses; modes 1-3 also 4-bit.
// - Mode 1: pixel is address bit 0, page gives upper seven bits.
// - Mode 1 carries up to 32 one-bit pixels per load.
// - Mode 2: two-bit pixel low, page upper six, up to 16 per load.
// - Mode 3: four-bit pixel low, page upper four, ratios 1,2,4,8.
// - Mode 4: pixel gives all eight address bits, ratios 1,2,4.
// - Normal modes accept little-endian by default, or big-endian.
// - Nibble mode only when nibble bit set and split-transfer bit clear.
// - Nibble mode overrides every other mode and ignores mux code.
// - Nibble mode: flag picks low or high nibble of four bytes.
// - Nibble mode: pixel gives low four bits, page the upper four.
// - True color: blue, green, red bytes direct; low byte is masked overlay.
// - Mode 1 ratios 4, 8, 16, 32 for 4 to 32-bit buses.
module ppm_top
    import ppm_pkg::*;
#(
    parameter int unsigned PIX_W = 32,
    parameter int unsigned VGA_W = 8
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // AHB-Lite register bus
    input  wire logic             hsel_i,
    input  wire logic [31:0]      haddr_i,
    input  wire logic [1:0]       htrans_i,
    input  wire logic             hwrite_i,
    input  wire logic [2:0]       hsize_i,
    input  wire logic [31:0]      hwdata_i,
    input  wire logic             hready_i,
    output logic      [31:0]      hrdata_o,
    output logic                  hreadyout_o,
    output logic                  hresp_o,
    // Pixel source pins
    input  wire logic [PIX_W-1:0] pixel_port_lines_i,
    input  wire logic [VGA_W-1:0] vga_pixel_i,
    input  wire logic             shift_clock_i,
    input  wire logic             pixel_rate_clock_i,
    input  wire logic             clock_source_zero_i,
    input  wire logic             split_or_nibble_flag_input_i,
    // Palette address output
    output logic      [7:0]       palette_addr_o,
    output logic                  palette_valid_o,
    // Direct colour output
    output logic      [7:0]       blue_o,
    output logic      [7:0]       green_o,
    output logic      [7:0]       red_o,
    output logic      [7:0]       overlay_o,
    output logic                  direct_valid_o
);

    // Decode a mux code into state, bits per pixel and pixels per load
    function automatic ppm_dec_t ppm_decode(input logic [5:0] code);
        ppm_dec_t d;

        d = '{st: PPM_HALT, bpp: 4'h8, ppl: 6'h01};
        case (code)
            6'h10: d = '{st: PPM_INDEX, bpp: 4'h1, ppl: 6'h04};
            6'h11: d = '{st: PPM_INDEX, bpp: 4'h1, ppl: 6'h08};
            6'h12: d = '{st: PPM_INDEX, bpp: 4'h1, ppl: 6'h10};
            // mode 1 at 32 per load
            6'h13: d = '{st: PPM_INDEX, bpp: 4'h1, ppl: 6'h20};
            6'h14: d = '{st: PPM_INDEX, bpp: 4'h2, ppl: 6'h02};
            6'h15: d = '{st: PPM_INDEX, bpp: 4'h2, ppl: 6'h04};
            6'h16: d = '{st: PPM_INDEX, bpp: 4'h2, ppl: 6'h08};
            6'h17: d = '{st: PPM_INDEX, bpp: 4'h2, ppl: 6'h10};
            6'h18: d = '{st: PPM_INDEX, bpp: 4'h4, ppl: 6'h01};
            6'h19: d = '{st: PPM_INDEX, bpp: 4'h4, ppl: 6'h02};
            6'h1A: d = '{st: PPM_INDEX, bpp: 4'h4, ppl: 6'h04};
            6'h1B: d = '{st: PPM_INDEX, bpp: 4'h4, ppl: 6'h08};
            6'h1C: d = '{st: PPM_INDEX, bpp: 4'h8, ppl: 6'h01};
            6'h1D: d = '{st: PPM_INDEX, bpp: 4'h8, ppl: 6'h02};
            6'h1E: d = '{st: PPM_INDEX, bpp: 4'h8, ppl: 6'h04};
            PPM_CODE_TRUE_E: d = '{st: PPM_TRUE, bpp: 4'h8, ppl: 6'h01};
            PPM_CODE_TRUE_F: d = '{st: PPM_TRUE, bpp: 4'h8, ppl: 6'h01};
            PPM_CODE_PASS: d = '{st: PPM_PASS, bpp: 4'h8, ppl: 6'h01};
            default: d = '{st: PPM_HALT, bpp: 4'h8, ppl: 6'h01};
        endcase
        return d;
    endfunction

    // Pick pixel group idx of width bpp out of a bus load
    function automatic logic [7:0] ppm_group(input logic [31:0] w,
                                             input logic [3:0]  bpp,
                                             input logic [5:0]  idx);
        logic [9:0]  pos;
        logic [31:0] sh;
        logic [7:0]  m;

        pos = 10'(idx) * 10'(bpp);
        sh  = w >> pos;
        case (bpp)
            4'h1:    m = 8'h01;
            4'h2:    m = 8'h03;
            4'h4:    m = 8'h0F;
            default: m = 8'hFF;
        endcase
        return sh[7:0] & m;
    endfunction

    // Join a pixel with the palette page into a palette address
    function automatic logic [7:0] ppm_addr(input logic [7:0] px,
                                            input logic [3:0] bpp,
                                            input logic [7:0] page);
        logic [7:0] a;

        case (bpp)
            4'h1:    a = {page[7:1], px[0]};
            4'h2:    a = {page[7:2], px[1:0]};
            4'h4:    a = {page[7:4], px[3:0]};
            default: a = px;
        endcase
        return a;
    endfunction

    // Register contents towards the core
    ppm_cfg_if cfg_if ();

    // Register slave
    ppm_regs u_regs (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .hsel_i      (hsel_i),
        .haddr_i     (haddr_i),
        .htrans_i    (htrans_i),
        .hwrite_i    (hwrite_i),
        .hwdata_i    (hwdata_i),
        .hready_i    (hready_i),
        .hrdata_o    (hrdata_o),
        .hreadyout_o (hreadyout_o),
        .hresp_o     (hresp_o),
        .cfg         (cfg_if.regs)
    );

    // Pin bundle: pixel bus, feature bus, three strobes and the nibble flag
    localparam int unsigned SYNC_W = PIX_W + VGA_W + 4;

    logic [SYNC_W-1:0] meta_r;
    logic [SYNC_W-1:0] sync_r;
    logic [2:0]        strb_prev_r;

    // Mode, captured load and group walk
    ppm_state_t        mode_r;
    ppm_state_t        mode_nxt;
    logic [31:0]       load_r;
    logic [3:0]        bpp_r;
    logic [5:0]        ratio_r;
    logic              big_r;

    logic [5:0]        cnt_r;
    logic              active_r;

    // Two-flop synchronisers for every pin input
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= {split_or_nibble_flag_input_i, clock_source_zero_i,
                       pixel_rate_clock_i, shift_clock_i, vga_pixel_i, pixel_port_lines_i};
            sync_r <= meta_r;
        end
    end

    // Synchronised pin views
    wire [PIX_W-1:0] pix_s   = sync_r[PIX_W-1:0];
    wire [VGA_W-1:0] vga_s   = sync_r[PIX_W +: VGA_W];

    wire             sclk_s  = sync_r[PIX_W+VGA_W];
    wire             dot_s   = sync_r[PIX_W+VGA_W+1];
    wire             clock_source_zero_s  = sync_r[PIX_W+VGA_W+2];
    wire             nibble_select_flag_s = sync_r[PIX_W+VGA_W+3];

    // Edge history of the three strobes
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            strb_prev_r <= 3'b000;
        end else begin
            strb_prev_r <= {clock_source_zero_s, dot_s, sclk_s};
        end
    end

    // Rise pulses of the synchronised strobes
    wire sclk_rise = sclk_s && !strb_prev_r[0];
    wire dot_rise  = dot_s && !strb_prev_r[1];
    wire clock_source_zero_rise = clock_source_zero_s && !strb_prev_r[2];

    wire [5:0]  code = cfg_if.mux_ctrl[5:0];
    // nibble bit set, split bit clear
    wire        nib_en = cfg_if.gen_ctrl[PPM_GC_NIBBLE_BIT] &&
                         !cfg_if.gen_ctrl[PPM_GC_SPLIT_BIT];
    wire        big_en = cfg_if.gen_ctrl[PPM_GC_BIGEND_BIT];

    ppm_dec_t   dec;
    assign dec = nib_en ? ppm_dec_t'{st: PPM_NIBBLE, bpp: PPM_NIB_BPP, ppl: PPM_NIB_PPL}
                        : ppm_decode(code);

    // Programmed divide ratio, zero read as one and capped at the bus width
    wire [5:0]  ratio_prog = (cfg_if.clk_sel[5:0] == 6'h00) ? 6'h01 :
                             (cfg_if.clk_sel[5:0] > 6'h20)  ? 6'h20 :
                             cfg_if.clk_sel[5:0];

    // ratio must equal pixels per load
    wire        mismatch = (ratio_prog != dec.ppl);

    // Mode state follows the configuration
    always_comb begin
        case (dec.st)
            PPM_PASS:   mode_nxt = PPM_PASS;
            PPM_INDEX:  mode_nxt = PPM_INDEX;
            PPM_NIBBLE: mode_nxt = PPM_NIBBLE;
            PPM_TRUE:   mode_nxt = PPM_TRUE;
            default:    mode_nxt = PPM_HALT;
        endcase
    end

    // nibble of each byte by flag
    wire [15:0] nib_word = nibble_select_flag_s ? {pix_s[31:28], pix_s[23:20], pix_s[15:12], pix_s[7:4]}
                                   : {pix_s[27:24], pix_s[19:16], pix_s[11:8], pix_s[3:0]};

    // pass-through loads on first clock source
    // normal modes load on shift clock
    wire        cap_evt = (mode_r == PPM_PASS) ? clock_source_zero_rise :
                          (mode_r != PPM_HALT) && sclk_rise;

    // lines above the used width are ignored
    wire [31:0] src_word = (mode_r == PPM_PASS)   ? 32'(vga_s) :
                           (mode_r == PPM_NIBBLE) ? {16'h0000, nib_word} :
                           32'(pix_s);

    wire [5:0]  ratio_cap = (mode_r == PPM_PASS) ? 6'h01 : ratio_prog;

    // A dot in a capture cycle is dropped; the load restarts
    wire        dot_evt  = dot_rise && active_r && !cap_evt && (mode_r != PPM_PASS);

    wire [5:0]  next_cnt = cnt_r + 6'h01;

    wire [5:0]  idx_cap  = big_en ? (ratio_cap - 6'h01) : 6'h00;
    wire [5:0]  idx_dot  = big_r ? (ratio_r - 6'h01 - next_cnt) : next_cnt;

    wire [31:0] emit_w   = cap_evt ? src_word : load_r;
    wire [3:0]  emit_bpp = cap_evt ? dec.bpp : bpp_r;
    wire [5:0]  emit_idx = cap_evt ? idx_cap : idx_dot;
    wire        emit     = cap_evt || dot_evt;

    wire [7:0]  group    = ppm_group(emit_w, emit_bpp, emit_idx);
    wire [7:0]  pal_addr = ppm_addr(group, emit_bpp, cfg_if.page) & cfg_if.read_mask;

    // Mode state register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_r <= PPM_PASS;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // capture load, then shift per dot
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            load_r   <= 32'h00000000;
            bpp_r    <= 4'h8;
            ratio_r  <= 6'h01;
            big_r    <= 1'b0;
            cnt_r    <= 6'h00;
            active_r <= 1'b0;
        end else if (cap_evt) begin
            load_r   <= src_word;
            bpp_r    <= dec.bpp;
            ratio_r  <= ratio_cap;
            big_r    <= big_en;
            cnt_r    <= 6'h00;
            active_r <= (ratio_cap > 6'h01);
        end else if (dot_evt) begin
            cnt_r    <= (next_cnt == ratio_r - 6'h01) ? 6'h00 : next_cnt;
            active_r <= (next_cnt != ratio_r - 6'h01);
        end
    end

    // Palette address output stage
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            palette_addr_o  <= 8'h00;
            palette_valid_o <= 1'b0;
        end else begin
            palette_valid_o <= emit && (mode_r != PPM_TRUE);
            if (emit && (mode_r != PPM_TRUE)) begin
                palette_addr_o <= pal_addr;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            blue_o         <= 8'h00;
            green_o        <= 8'h00;
            red_o          <= 8'h00;
            overlay_o      <= 8'h00;
            direct_valid_o <= 1'b0;
        end else begin
            direct_valid_o <= emit && (mode_r == PPM_TRUE);
            if (emit && (mode_r == PPM_TRUE)) begin
                blue_o    <= emit_w[31:24];
                green_o   <= emit_w[23:16];
                red_o     <= emit_w[15:8];
                overlay_o <= emit_w[7:0] & cfg_if.read_mask;
            end
        end
    end

    // Status seen by software
    assign cfg_if.status = {10'h000, cnt_r, 6'h00, active_r, mismatch, 3'b000, mode_r};

endmodule : ppm_top

//--- src/ppm_pkg.sv
// Package of the palette pixel port multiplexer: register map, reset values,
// mux codes, field positions and the decoded mode type.
// Assumes one 20 MHz clock and a 32-bit AHB-Lite register bus.
package ppm_pkg;

    // Clock of the block
    localparam int unsigned CLK_HZ = 20_000_000;

    // Register byte offsets
    localparam logic [7:0] PPM_OFS_MUX_CTRL  = 8'h00;
    localparam logic [7:0] PPM_OFS_GEN_CTRL  = 8'h04;
    localparam logic [7:0] PPM_OFS_CLK_SEL   = 8'h08;
    localparam logic [7:0] PPM_OFS_PAGE      = 8'h0C;
    localparam logic [7:0] PPM_OFS_READ_MASK = 8'h10;
    localparam logic [7:0] PPM_OFS_STATUS    = 8'h14;

    // Values after reset
    localparam logic [7:0] PPM_RST_MUX_CTRL  = 8'h2D;
    localparam logic [7:0] PPM_RST_GEN_CTRL  = 8'h00;
    localparam logic [7:0] PPM_RST_CLK_SEL   = 8'h01;
    localparam logic [7:0] PPM_RST_PAGE      = 8'h00;
    localparam logic [7:0] PPM_RST_READ_MASK = 8'hFF;

    // General control field positions
    localparam int unsigned PPM_GC_SPLIT_BIT  = 2;
    localparam int unsigned PPM_GC_NIBBLE_BIT = 3;
    localparam int unsigned PPM_GC_BIGEND_BIT = 5;

    // Mux codes (bits 5..0 only)
    localparam logic [5:0] PPM_CODE_PASS     = 6'h2D;
    localparam logic [5:0] PPM_CODE_TRUE_E   = 6'h0E;
    localparam logic [5:0] PPM_CODE_TRUE_F   = 6'h0D;
    localparam logic [3:0] PPM_NIB_BPP       = 4'h4;
    localparam logic [5:0] PPM_NIB_PPL       = 6'h04;

    // Status field positions
    localparam int unsigned PPM_ST_STATE_LSB = 0;
    localparam int unsigned PPM_ST_MISM_BIT  = 8;
    localparam int unsigned PPM_ST_ACT_BIT   = 9;
    localparam int unsigned PPM_ST_CNT_LSB   = 16;

    // Operating states of the multiplexer
    typedef enum logic [4:0] {
        PPM_PASS   = 5'b00001,
        PPM_INDEX  = 5'b00010,
        PPM_NIBBLE = 5'b00100,
        PPM_TRUE   = 5'b01000,
        PPM_HALT   = 5'b10000
    } ppm_state_t;

    // Decoded mode: state, bits per pixel, pixels per bus load
    typedef struct packed {
        ppm_state_t  st;
        logic [3:0]  bpp;
        logic [5:0]  ppl;
    } ppm_dec_t;

endpackage : ppm_pkg

//--- src/ppm_cfg_if.sv
// Interface carrying register contents to the pixel core and its state back.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface ppm_cfg_if;
    logic [7:0]  mux_ctrl;
    logic [7:0]  gen_ctrl;
    logic [7:0]  clk_sel;
    logic [7:0]  page;
    logic [7:0]  read_mask;
    logic [31:0] status;

    modport regs (output mux_ctrl, gen_ctrl, clk_sel, page, read_mask, input status);
    modport core (input mux_ctrl, gen_ctrl, clk_sel, page, read_mask, output status);
endinterface : ppm_cfg_if

//--- src/ppm_regs.sv
// AHB-Lite register slave of the pixel port multiplexer.
// Assumes single word transfers; answers with zero wait states and OKAY.
`timescale 1ns/1ps
module ppm_regs
    import ppm_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // AHB-Lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    // Configuration towards the core
    ppm_cfg_if.regs          cfg
);

    logic [7:0]  mux_r, gen_r, clk_r, page_r, mask_r;
    logic [7:0]  mux_nxt, gen_nxt, clk_nxt, page_nxt, mask_nxt;
    logic        wr_pend_r;
    logic [7:0]  wr_addr_r;
    logic [31:0] rd_nxt;
    wire         addr_ok  = hsel_i && htrans_i[1] && hready_i;
    wire         wr_mux   = wr_pend_r && (wr_addr_r == PPM_OFS_MUX_CTRL);
    wire         to_pass  = wr_mux && (hwdata_i[5:0] == PPM_CODE_PASS);

    // Register next values from the pending write
    assign mux_nxt  = wr_mux ? hwdata_i[7:0] : mux_r;
    assign gen_nxt  = to_pass ? PPM_RST_GEN_CTRL :
                      (wr_pend_r && wr_addr_r == PPM_OFS_GEN_CTRL) ? hwdata_i[7:0] : gen_r;
    assign clk_nxt  = to_pass ? PPM_RST_CLK_SEL :
                      (wr_pend_r && wr_addr_r == PPM_OFS_CLK_SEL) ? hwdata_i[7:0] : clk_r;
    assign mask_nxt = to_pass ? PPM_RST_READ_MASK :
                      (wr_pend_r && wr_addr_r == PPM_OFS_READ_MASK) ? hwdata_i[7:0] : mask_r;
    assign page_nxt = (wr_pend_r && wr_addr_r == PPM_OFS_PAGE) ? hwdata_i[7:0] : page_r;

    // Read selection, forwarding a write in flight; unmapped reads zero
    assign rd_nxt = (haddr_i[7:0] == PPM_OFS_MUX_CTRL)  ? {24'h000000, mux_nxt}  :
                    (haddr_i[7:0] == PPM_OFS_GEN_CTRL)  ? {24'h000000, gen_nxt}  :
                    (haddr_i[7:0] == PPM_OFS_CLK_SEL)   ? {24'h000000, clk_nxt}  :
                    (haddr_i[7:0] == PPM_OFS_PAGE)      ? {24'h000000, page_nxt} :
                    (haddr_i[7:0] == PPM_OFS_READ_MASK) ? {24'h000000, mask_nxt} :
                    (haddr_i[7:0] == PPM_OFS_STATUS)    ? cfg.status             :
                                                          32'h00000000;

    // Address phase capture, register update and read data
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mux_r       <= PPM_RST_MUX_CTRL;
            gen_r       <= PPM_RST_GEN_CTRL;
            clk_r       <= PPM_RST_CLK_SEL;
            page_r      <= PPM_RST_PAGE;
            mask_r      <= PPM_RST_READ_MASK;
            wr_pend_r   <= 1'b0;
            wr_addr_r   <= 8'h00;
            hrdata_o    <= 32'h00000000;
            hreadyout_o <= 1'b0;
            hresp_o     <= 1'b0;
        end else begin
            mux_r       <= mux_nxt;
            gen_r       <= gen_nxt;
            clk_r       <= clk_nxt;
            page_r      <= page_nxt;
            mask_r      <= mask_nxt;
            wr_pend_r   <= addr_ok && hwrite_i && (haddr_i[31:8] == 24'h000000);
            wr_addr_r   <= haddr_i[7:0];
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
            if (addr_ok && !hwrite_i) begin
                hrdata_o <= (haddr_i[31:8] == 24'h000000) ? rd_nxt : 32'h00000000;
            end
        end
    end

    assign cfg.mux_ctrl  = mux_r;
    assign cfg.gen_ctrl  = gen_r;
    assign cfg.clk_sel   = clk_r;
    assign cfg.page      = page_r;
    assign cfg.read_mask = mask_r;

endmodule : ppm_regs

//--- bench/ppm_top_sva.sv
// Checker of the pixel port multiplexer, bound to its top ports.
// Assumes one clock domain with the asynchronous active-low reset.
`timescale 1ns/1ps
module ppm_top_sva (
    // Clock, reset and bus
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hwrite_i,
    input wire logic [31:0] hrdata_o,
    input wire logic        hreadyout_o,
    input wire logic        hresp_o,
    // Pixel side
    input wire logic        shift_clock_i,
    input wire logic        pixel_rate_clock_i,
    input wire logic        clock_source_zero_i,
    input wire logic [7:0]  palette_addr_o,
    input wire logic        palette_valid_o,
    input wire logic        direct_valid_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Bus answers at once and always OKAY
    property p_okay; hresp_o == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("hresp not OKAY");
    property p_ready; $past(rst_n_i) |-> hreadyout_o; endproperty
    a_ready: assert property (p_ready) else $error("wait state inserted");
    property p_unmap; hsel_i && htrans_i[1] && !hwrite_i && hreadyout_o
        && haddr_i[31:8] != 24'h000000 |=> hrdata_o == 32'h00000000; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    // Pixel pulses, their cause and held values
    property p_pal_pulse; palette_valid_o |=> !palette_valid_o; endproperty
    a_pal_pulse: assert property (p_pal_pulse) else $error("long palette pulse");
    property p_hold; !palette_valid_o |-> $stable(palette_addr_o); endproperty
    a_hold: assert property (p_hold) else $error("address moved");
    property p_dir_pulse; direct_valid_o |=> !direct_valid_o; endproperty
    a_dir_pulse: assert property (p_dir_pulse) else $error("long direct pulse");
    property p_excl; !(palette_valid_o && direct_valid_o); endproperty
    a_excl: assert property (p_excl) else $error("both outputs valid");
    property p_quiet; (!shift_clock_i && !pixel_rate_clock_i && !clock_source_zero_i)[*8]
        |=> !palette_valid_o && !direct_valid_o; endproperty
    a_quiet: assert property (p_quiet) else $error("pixel without strobe");
    // Main scenarios reached
    c_pal: cover property (palette_valid_o);
    c_dir: cover property (direct_valid_o);
    c_pass: cover property ($rose(clock_source_zero_i) ##[1:8] palette_valid_o);
endmodule // ppm_top_sva

bind ppm_top ppm_top_sva i_ppm_top_sva (.clk_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i,
    .hwrite_i, .hrdata_o, .hreadyout_o, .hresp_o, .shift_clock_i, .pixel_rate_clock_i,
    .clock_source_zero_i, .palette_addr_o, .palette_valid_o, .direct_valid_o);

//--- bench/ppm_src_model.sv
// Pixel source model: memory shift outputs and feature connector bus.
// Assumes calls start just after a rising edge of clk_i.
`timescale 1ns/1ps
module ppm_src_model (
    // Clock
    input  wire logic        clk_i,
    // Pixel pins
    output logic      [31:0] pix_o,
    output logic      [7:0]  vga_o,
    output logic             shift_o,
    output logic             dot_o,
    output logic             src0_o,
    output logic             nib_o
);
    initial {pix_o, vga_o, shift_o, dot_o, src0_o, nib_o} = '0;
    // One load on a w-bit bus, then n dot strobes; levels last four cycles
    task automatic send(input logic [31:0] d, input int w, input logic f, p, input int n);
        pix_o <= d;
        vga_o <= d[7:0];
        nib_o <= f;
        @(posedge clk_i);
        shift_o <= !p;
        src0_o <= p;
        repeat (4) @(posedge clk_i);
        pix_o <= ~d & (32'hFFFFFFFF >> (32 - w));
        {shift_o, src0_o, nib_o, vga_o} <= {2'b00, !f, ~d[7:0]};
        repeat (4) @(posedge clk_i);
        repeat (n) begin
            dot_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            dot_o <= 1'b0;
            repeat (4) @(posedge clk_i);
        end
    endtask
endmodule // ppm_src_model

//--- bench/tb_ppm_top.sv
// Bench of the pixel port multiplexer: registers and pixel modes.
// Assumes the source model on the pins and single AHB-Lite transfers.
`timescale 1ns/1ps
module tb_ppm_top;
    import ppm_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        hsel = 1'b0;
    logic        hwr = 1'b0;
    logic [1:0]  htr = 2'b00;
    logic [31:0] hadr = '0;
    logic [31:0] hwd = '0;
    logic [31:0] hrd, pix;
    logic [7:0]  vga, pa, b, g, r, ov;
    logic        rdy, rsp, sh, dot, s0, nf, pv, dv;
    logic [31:0] seen[$];
    int          failures = 0;
    int          checks_done = 0;
    // Clock of 50 ns
    always #25 clk_i = ~clk_i;
    ppm_top i_ppm_top (.clk_i, .rst_n_i, .hsel_i(hsel), .haddr_i(hadr), .htrans_i(htr),
        .hwrite_i(hwr), .hsize_i(3'b010), .hwdata_i(hwd), .hready_i(rdy), .hrdata_o(hrd),
        .hreadyout_o(rdy), .hresp_o(rsp), .pixel_port_lines_i(pix), .vga_pixel_i(vga),
        .shift_clock_i(sh), .pixel_rate_clock_i(dot), .clock_source_zero_i(s0),
        .split_or_nibble_flag_input_i(nf), .palette_addr_o(pa), .palette_valid_o(pv),
        .blue_o(b), .green_o(g), .red_o(r), .overlay_o(ov), .direct_valid_o(dv));
    ppm_src_model i_ppm_src_model (.clk_i, .pix_o(pix), .vga_o(vga), .shift_o(sh),
        .dot_o(dot), .src0_o(s0), .nib_o(nf));
    // Record every emitted pixel
    always @(posedge clk_i) begin
        if (pv === 1'b1) seen.push_back({24'h000000, pa});
        if (dv === 1'b1) seen.push_back({b, g, r, ov});
    end
    task automatic test_done;
        if (failures == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Wait for hready under a bound
    task automatic wait_rdy;
        @(posedge clk_i);
        for (int n = 0; rdy !== 1'b1; n++) begin
            failures += int'(n == 20);
            if (n == 20)
                test_done();
            @(posedge clk_i);
        end
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] q);
        {hsel, hwr, htr, hadr} <= {1'b1, w, 2'b10, a};
        wait_rdy();
        {hsel, htr, hwd} <= {1'b0, 2'b00, d};
        wait_rdy();
        q = hrd;
    endtask
    task automatic wr(input logic [7:0] a, d);
        logic [31:0] q;
        ahb(1'b1, {24'h000000, a}, {24'h000000, d}, q);
    endtask
    task automatic rd(input logic [7:0] a, e);
        logic [31:0] q;
        ahb(1'b0, {24'h000000, a}, 32'h00000000, q);
        chk(q, {24'h000000, e});
    endtask
    // Program a mode, send one load, compare the pixels in order
    task automatic run(input logic [7:0] mux, gen, sel, pg, input logic [31:0] d,
                       input int w, input logic f, input int n, input logic [31:0] e[$]);
        wr(PPM_OFS_MUX_CTRL, mux);
        wr(PPM_OFS_GEN_CTRL, gen);
        wr(PPM_OFS_CLK_SEL, sel);
        wr(PPM_OFS_PAGE, pg);
        i_ppm_src_model.send(d, w, f, 1'b0, n);
        repeat (4) @(posedge clk_i);
        chk(seen.size(), e.size());
        foreach (e[i]) chk(seen[i], e[i]);
        seen.delete();
    endtask
    task automatic sc_reset;
        rd(PPM_OFS_MUX_CTRL, 8'h2D);
        rd(PPM_OFS_CLK_SEL, 8'h01);
        i_ppm_src_model.send(32'h000000A5, 8, 1'b0, 1'b1, 1);
        repeat (4) @(posedge clk_i);
        chk(seen.pop_front(), 32'h000000A5);
    endtask
    task automatic sc_index;
        run(8'hDD, 8'h00, 8'h02, 8'h00, 32'h3C5A, 16, 1'b0, 2, '{32'h5A, 32'h3C});
        run(8'h19, 8'h00, 8'h02, 8'hA0, 32'hE7, 8, 1'b0, 1, '{32'hA7, 32'hAE});
        run(8'h10, 8'h00, 8'h04, 8'h36, 32'hA, 4, 1'b0, 3,
            '{32'h36, 32'h37, 32'h36, 32'h37});
        run(8'h15, 8'h00, 8'h04, 8'h50, 32'h1B, 8, 1'b0, 3,
            '{32'h53, 32'h52, 32'h51, 32'h50});
        run(8'h1D, 8'h20, 8'h02, 8'h00, 32'h3C5A, 16, 1'b0, 1, '{32'h3C, 32'h5A});
    endtask
    task automatic sc_nibble;
        run(8'h1D, 8'h08, 8'h04, 8'h90, 32'h87654321, 32, 1'b0, 3,
            '{32'h91, 32'h93, 32'h95, 32'h97});
        run(8'h1D, 8'h08, 8'h04, 8'h90, 32'h87654321, 32, 1'b1, 3,
            '{32'h92, 32'h94, 32'h96, 32'h98});
        run(8'h1D, 8'h0C, 8'h02, 8'h00, 32'h4321, 16, 1'b0, 1, '{32'h21, 32'h43});
    endtask
    task automatic sc_true;
        wr(PPM_OFS_READ_MASK, 8'h0F);
        run(8'h0E, 8'h00, 8'h01, 8'h00, 32'h11223344, 32, 1'b0, 0, '{32'h11223304});
    endtask
    task automatic sc_back;
        logic [31:0] q;
        wr(PPM_OFS_CLK_SEL, 8'h08);
        wr(PPM_OFS_GEN_CTRL, 8'h20);
        wr(PPM_OFS_MUX_CTRL, 8'hED);
        rd(PPM_OFS_CLK_SEL, 8'h01);
        rd(PPM_OFS_GEN_CTRL, 8'h00);
        rd(PPM_OFS_READ_MASK, 8'hFF);
        ahb(1'b0, 32'h00000100, 32'h00000000, q);
        chk(q, 32'h00000000);
    endtask
    // Reset, then every scenario in turn
    initial begin
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sc_reset();
        sc_index();
        sc_nibble();
        sc_true();
        sc_back();
        test_done();
    end
endmodule // tb_ppm_top
